// File: core/mcopc_defines.vh
`ifndef MCOPC_DEFINES_VH
`define MCOPC_DEFINES_VH

// ****************************************
// port and core geometry
// ****************************************
`define MCOPC_PINS       32
`define MCOPC_CORES      8
`define MCOPC_SEL_W      3

// ****************************************
// register byte offsets
// ****************************************
`define MCOPC_OFF_SEL    8'h00
`define MCOPC_OFF_RUN    8'h04
`define MCOPC_OFF_LATCH  8'h08
`define MCOPC_OFF_DIR    8'h0C
`define MCOPC_OFF_BIT    8'h10
`define MCOPC_OFF_RSEL   8'h14
`define MCOPC_OFF_RDATA  8'h18
`define MCOPC_OFF_PINS   8'h1C
`define MCOPC_OFF_PINOE  8'h20

// ****************************************
// decoded register codes
// ****************************************
`define MCOPC_R_NONE     4'h0
`define MCOPC_R_SEL      4'h1
`define MCOPC_R_RUN      4'h2
`define MCOPC_R_LATCH    4'h3
`define MCOPC_R_DIR      4'h4
`define MCOPC_R_BIT      4'h5
`define MCOPC_R_RSEL     4'h6
`define MCOPC_R_RDATA    4'h7
`define MCOPC_R_PINS     4'h8
`define MCOPC_R_PINOE    4'h9

// ****************************************
// field positions
// ****************************************
`define MCOPC_BIT_IDX_LO 0
`define MCOPC_BIT_IDX_HI 4
`define MCOPC_BIT_VAL    8
`define MCOPC_RSEL_X_LO  0
`define MCOPC_RSEL_X_HI  4
`define MCOPC_RSEL_Y_LO  8
`define MCOPC_RSEL_Y_HI  12

// ****************************************
// reset values and bus answers
// ****************************************
`define MCOPC_LATCH_RST  32'h0000_0000
`define MCOPC_DIR_RST    32'h0000_0000
`define MCOPC_RUN_RST    8'h00
`define MCOPC_RSP_OKAY   2'h0
`define MCOPC_RSP_SLVERR 2'h2

`endif

// File: core/mcopc_top.v
`timescale 1ns/1ns
`default_nettype none
`include "mcopc_defines.vh"
module mcopc_top (
	input  wire         I_SYS_CLK,      // system clock
	input  wire         I_RESETN,       // async reset, low
	input  wire [255:0] I_CORE_AUX,     // other sources, 32/core
	input  wire [7:0]   I_AXI_AWADDR,   // write address
	input  wire         I_AXI_AWVALID,  // write address valid
	output wire         O_AXI_AWREADY,  // write address ready
	input  wire [31:0]  I_AXI_WDATA,    // write data
	input  wire [3:0]   I_AXI_WSTRB,    // byte enables
	input  wire         I_AXI_WVALID,   // write data valid
	output wire         O_AXI_WREADY,   // write data ready
	output wire [1:0]   O_AXI_BRESP,    // write response
	output wire         O_AXI_BVALID,   // write response valid
	input  wire         I_AXI_BREADY,   // write response ready
	input  wire [7:0]   I_AXI_ARADDR,   // read address
	input  wire         I_AXI_ARVALID,  // read address valid
	output wire         O_AXI_ARREADY,  // read address ready
	output wire [31:0]  O_AXI_RDATA,    // read data
	output wire [1:0]   O_AXI_RRESP,    // read response
	output wire         O_AXI_RVALID,   // read data valid
	input  wire         I_AXI_RREADY,   // read data ready
	output wire [31:0]  O_PIN_OUT,      // pin output levels
	output wire [31:0]  O_PIN_OE        // pin output enables
);
	// ****************************************
	// functions
	// ****************************************
	function [3:0] dec;
		input [7:0] a;
		begin
			if (a == `MCOPC_OFF_SEL)
				dec = `MCOPC_R_SEL;
			else if (a == `MCOPC_OFF_RUN)
				dec = `MCOPC_R_RUN;
			else if (a == `MCOPC_OFF_LATCH)
				dec = `MCOPC_R_LATCH;
			else if (a == `MCOPC_OFF_DIR)
				dec = `MCOPC_R_DIR;
			else if (a == `MCOPC_OFF_BIT)
				dec = `MCOPC_R_BIT;
			else if (a == `MCOPC_OFF_RSEL)
				dec = `MCOPC_R_RSEL;
			else if (a == `MCOPC_OFF_RDATA)
				dec = `MCOPC_R_RDATA;
			else if (a == `MCOPC_OFF_PINS)
				dec = `MCOPC_R_PINS;
			else if (a == `MCOPC_OFF_PINOE)
				dec = `MCOPC_R_PINOE;
			else
				dec = `MCOPC_R_NONE;
		end
	endfunction
	function [31:0] merge;
		input [31:0] old;
		input [31:0] d;
		input [3:0]  s;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (s[b])
					merge[b*8 +: 8] = d[b*8 +: 8];
			end
		end
	endfunction
	// position of value bit k in a range x..y, or 32 if outside
	function [5:0] rpos;
		input [4:0] x;
		input [4:0] y;
		input [5:0] k;
		begin
			if (x >= y)
				rpos = (k <= {1'b0, x - y}) ?
					{1'b0, y} + k : 6'h20;
			else
				rpos = (k <= {1'b0, y - x}) ?
					{1'b0, y} - k : 6'h20;
		end
	endfunction
	function [31:0] rng_wr;
		input [31:0] old;
		input [31:0] d;
		input [4:0]  x;
		input [4:0]  y;
		integer k;
		reg [5:0] p;
		begin
			rng_wr = old;
			for (k = 0; k < 32; k = k + 1) begin
				p = rpos(x, y, k[5:0]);
				if (p < 6'd32)
					rng_wr[p[4:0]] = d[k];
			end
		end
	endfunction
	function [31:0] rng_rd;
		input [31:0] l;
		input [4:0]  x;
		input [4:0]  y;
		integer k;
		reg [5:0] p;
		begin
			rng_rd = 32'h0000_0000;
			for (k = 0; k < 32; k = k + 1) begin
				p = rpos(x, y, k[5:0]);
				if (p < 6'd32)
					rng_rd[k] = l[p[4:0]];
			end
		end
	endfunction
	// ****************************************
	// state
	// ****************************************
	reg  [31:0] latch_r [0:7];
	reg  [31:0] dir_r   [0:7];
	reg  [7:0]  run_r;
	reg  [7:0]  run_prev_r;
	reg  [2:0]  sel_r;
	reg  [4:0]  bit_idx_r;
	reg  [4:0]  rx_r;
	reg  [4:0]  ry_r;
	reg  [31:0] pin_r;
	reg  [31:0] oe_r;
	reg  [31:0] pin_nxt;
	reg  [31:0] oe_nxt;
	reg  [7:0]  awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg         aw_full_r;
	reg         w_full_r;
	reg         awrdy_r;
	reg         wrdy_r;
	reg         bvalid_r;
	reg  [1:0]  bresp_r;
	reg         arrdy_r;
	reg         rvalid_r;
	reg  [31:0] rdata_r;
	reg  [1:0]  rresp_r;
	reg         aw_full_nxt;
	reg         w_full_nxt;
	reg         bvalid_nxt;
	reg         rvalid_nxt;
	wire        aw_hs = I_AXI_AWVALID & awrdy_r;
	wire        w_hs  = I_AXI_WVALID & wrdy_r;
	wire        ar_hs = I_AXI_ARVALID & arrdy_r;
	wire        do_wr = aw_full_r & w_full_r & ~bvalid_r;
	wire [3:0]  wreg  = dec(awaddr_r);
	wire [3:0]  rreg  = dec(I_AXI_ARADDR);
	wire [31:0] cur_l = latch_r[sel_r];
	wire [31:0] cur_d = dir_r[sel_r];
	wire        act   = do_wr & (wstrb_r != 4'h0);
	integer     c;
	integer     m;
	// ****************************************
	// write channel handshake
	// ****************************************
	always @* begin
		aw_full_nxt = aw_full_r;
		w_full_nxt  = w_full_r;
		bvalid_nxt  = bvalid_r;
		if (do_wr) begin
			aw_full_nxt = 1'b0;
			w_full_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
		end
		if (aw_hs)
			aw_full_nxt = 1'b1;
		if (w_hs)
			w_full_nxt = 1'b1;
		if (bvalid_r & I_AXI_BREADY)
			bvalid_nxt = 1'b0;
	end
	always @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awrdy_r   <= 1'b0;
			wrdy_r    <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `MCOPC_RSP_OKAY;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			bvalid_r  <= bvalid_nxt;
			awrdy_r   <= ~aw_full_nxt & ~bvalid_nxt;
			wrdy_r    <= ~w_full_nxt & ~bvalid_nxt;
			if (aw_hs)
				awaddr_r <= I_AXI_AWADDR;
			if (w_hs) begin
				wdata_r <= I_AXI_WDATA;
				wstrb_r <= I_AXI_WSTRB;
			end
			if (do_wr)
				bresp_r <= (wreg == `MCOPC_R_NONE ||
					wreg == `MCOPC_R_PINS ||
					wreg == `MCOPC_R_PINOE) ?
					`MCOPC_RSP_SLVERR : `MCOPC_RSP_OKAY;
		end
	end
	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			sel_r      <= 3'h0;
			run_r      <= `MCOPC_RUN_RST;
			run_prev_r <= `MCOPC_RUN_RST;
			bit_idx_r  <= 5'h00;
			rx_r       <= 5'h00;
			ry_r       <= 5'h00;
		end else begin
			run_prev_r <= run_r;
			if (do_wr && wreg == `MCOPC_R_SEL && wstrb_r[0])
				sel_r <= wdata_r[2:0];
			if (do_wr && wreg == `MCOPC_R_RUN && wstrb_r[0])
				run_r <= wdata_r[7:0];
			if (act && wreg == `MCOPC_R_BIT)
				bit_idx_r <= wdata_r[`MCOPC_BIT_IDX_HI:
					`MCOPC_BIT_IDX_LO];
			if (do_wr && wreg == `MCOPC_R_RSEL) begin
				if (wstrb_r[0])
					rx_r <= wdata_r[`MCOPC_RSEL_X_HI:
						`MCOPC_RSEL_X_LO];
				if (wstrb_r[1])
					ry_r <= wdata_r[`MCOPC_RSEL_Y_HI:
						`MCOPC_RSEL_Y_LO];
			end
		end
	end
	// ****************************************
	// per-core latches and directions
	// ****************************************
	always @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			for (c = 0; c < 8; c = c + 1) begin
				latch_r[c] <= `MCOPC_LATCH_RST;
				dir_r[c]   <= `MCOPC_DIR_RST;
			end
		end else begin
			for (c = 0; c < 8; c = c + 1) begin
				if (run_r[c] & ~run_prev_r[c]) begin
					latch_r[c] <= `MCOPC_LATCH_RST;
				end else if (do_wr && sel_r == c[2:0]) begin
					if (wreg == `MCOPC_R_LATCH)
						latch_r[c] <= merge(cur_l, wdata_r,
							wstrb_r);
					else if (act && wreg == `MCOPC_R_BIT)
						latch_r[c][wdata_r[4:0]] <=
							wdata_r[`MCOPC_BIT_VAL];
					else if (act && wreg == `MCOPC_R_RDATA)
						latch_r[c] <= rng_wr(cur_l, wdata_r,
							rx_r, ry_r);
				end
				if (do_wr && sel_r == c[2:0] &&
					wreg == `MCOPC_R_DIR)
					dir_r[c] <= merge(cur_d, wdata_r, wstrb_r);
			end
		end
	end
	// ****************************************
	// pin combination
	// ****************************************
	always @* begin
		pin_nxt = 32'h0000_0000;
		oe_nxt  = 32'h0000_0000;
		for (m = 0; m < 8; m = m + 1) begin
			// every core reaches every pin, gated by its dir_r mask and its run_r bit
			pin_nxt = pin_nxt | ((latch_r[m] |
				I_CORE_AUX[m*32 +: 32]) & dir_r[m] &
				{32{run_r[m]}});
			oe_nxt = oe_nxt | (dir_r[m] &
				{32{run_r[m]}});
		end
	end
	always @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pin_r <= 32'h0000_0000;
			oe_r  <= 32'h0000_0000;
		end else begin
			pin_r <= pin_nxt;
			oe_r  <= oe_nxt;
		end
	end
	// ****************************************
	// read channel
	// ****************************************
	always @* begin
		rvalid_nxt = rvalid_r;
		if (rvalid_r & I_AXI_RREADY)
			rvalid_nxt = 1'b0;
		if (ar_hs)
			rvalid_nxt = 1'b1;
	end
	always @(posedge I_SYS_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			arrdy_r  <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `MCOPC_RSP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arrdy_r  <= ~rvalid_nxt & ~ar_hs;
			if (ar_hs) begin
				rresp_r <= `MCOPC_RSP_OKAY;
				if (rreg == `MCOPC_R_SEL)
					rdata_r <= {29'h0, sel_r};
				else if (rreg == `MCOPC_R_RUN)
					rdata_r <= {24'h0, run_r};
				else if (rreg == `MCOPC_R_LATCH)
					rdata_r <= cur_l;
				else if (rreg == `MCOPC_R_DIR)
					rdata_r <= cur_d;
				else if (rreg == `MCOPC_R_BIT)
					rdata_r <= {23'h0, cur_l[bit_idx_r],
						3'h0, bit_idx_r};
				else if (rreg == `MCOPC_R_RSEL)
					rdata_r <= {19'h0, ry_r, 3'h0, rx_r};
				else if (rreg == `MCOPC_R_RDATA)
					rdata_r <= rng_rd(cur_l, rx_r,
						ry_r);
				else if (rreg == `MCOPC_R_PINS)
					rdata_r <= pin_r;
				else if (rreg == `MCOPC_R_PINOE)
					rdata_r <= oe_r;
				else begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= `MCOPC_RSP_SLVERR;
				end
			end
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign O_AXI_AWREADY = awrdy_r;
	assign O_AXI_WREADY  = wrdy_r;
	assign O_AXI_BRESP   = bresp_r;
	assign O_AXI_BVALID  = bvalid_r;
	assign O_AXI_ARREADY = arrdy_r;
	assign O_AXI_RDATA   = rdata_r;
	assign O_AXI_RRESP   = rresp_r;
	assign O_AXI_RVALID  = rvalid_r;
	assign O_PIN_OUT     = pin_r;
	assign O_PIN_OE      = oe_r;
endmodule
`default_nettype wire

// File: test/mcopc_pin_load.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// pin load: undriven pins pulled down
// ****************************************
module mcopc_pin_load (
	input  wire logic [31:0] i_pin_out, // pin levels
	input  wire logic [31:0] i_pin_oe,  // pin enables
	output wire logic [31:0] o_pad      // wire level
);
	assign o_pad = i_pin_out & i_pin_oe;
endmodule
`default_nettype wire

// File: test/mcopc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mcopc_top_chk (
	input wire logic        I_SYS_CLK,     // clock
	input wire logic        I_RESETN,      // reset, low
	input wire logic        I_AXI_AWVALID, // aw valid
	input wire logic        O_AXI_AWREADY, // aw ready
	input wire logic        I_AXI_WVALID,  // w valid
	input wire logic        O_AXI_WREADY,  // w ready
	input wire logic        O_AXI_BVALID,  // b valid
	input wire logic        I_AXI_BREADY,  // b ready
	input wire logic        I_AXI_ARVALID, // ar valid
	input wire logic        O_AXI_ARREADY, // ar ready
	input wire logic        O_AXI_RVALID,  // r valid
	input wire logic        I_AXI_RREADY,  // r ready
	input wire logic [31:0] O_PIN_OUT,     // pin levels
	input wire logic [31:0] O_PIN_OE       // pin enables
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESETN);
	property p_wr_ans;
		I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY
			|-> ##2 O_AXI_BVALID;
	endproperty
	property p_rd_ans;
		I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID;
	endproperty
	property p_b_done;
		O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID;
	endproperty
	property p_r_done;
		O_AXI_RVALID && I_AXI_RREADY |=> !O_AXI_RVALID;
	endproperty
	property p_ar_ref;
		O_AXI_RVALID |-> !O_AXI_ARREADY;
	endproperty
	property p_aw_ref;
		O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY;
	endproperty
	property p_ar_back;
		O_AXI_RVALID && I_AXI_RREADY |=> O_AXI_ARREADY;
	endproperty
	property p_gate;
		O_PIN_OE != 32'h0000_0000 || O_PIN_OUT == 32'h0000_0000;
	endproperty
	property p_sub;
		(O_PIN_OUT & ~O_PIN_OE) == 32'h0000_0000;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("late bvalid");
	a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
	a_b_done: assert property (p_b_done) else $error("bvalid stuck");
	a_r_done: assert property (p_r_done) else $error("rvalid stuck");
	a_ar_ref: assert property (p_ar_ref) else $error("ar taken");
	a_aw_ref: assert property (p_aw_ref) else $error("aw taken");
	a_ar_back: assert property (p_ar_back) else $error("ar idle");
	a_gate: assert property (p_gate) else $error("pin without oe");
	a_sub: assert property (p_sub) else $error("pin high undriven");
	c_wr: cover property (O_AXI_BVALID);
	c_rd: cover property (O_AXI_RVALID);
	c_pin: cover property (O_PIN_OUT != 32'h0000_0000);
endmodule
bind mcopc_top mcopc_top_chk mcopc_top_chk_inst (.*);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "mcopc_defines.vh"
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
module tb;
	logic         I_SYS_CLK = 0, I_RESETN = 0;
	logic [255:0] I_CORE_AUX = 0;
	logic [7:0]   I_AXI_AWADDR = 0, I_AXI_ARADDR = 0;
	logic [31:0]  I_AXI_WDATA = 0, rdat;
	logic [3:0]   I_AXI_WSTRB = 4'hF;
	logic         I_AXI_AWVALID = 0, I_AXI_WVALID = 0, I_AXI_ARVALID = 0;
	logic         I_AXI_BREADY = 1, I_AXI_RREADY = 1;
	logic [1:0]   rsp;
	wire  [31:0]  O_AXI_RDATA, O_PIN_OUT, O_PIN_OE, pad;
	wire  [1:0]   O_AXI_BRESP, O_AXI_RRESP;
	wire          O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID;
	wire          O_AXI_ARREADY, O_AXI_RVALID;
	int           n, miscompares = 0, num_checks = 0;
	mcopc_top mcopc_top_inst (.*);
	mcopc_pin_load mcopc_pin_load_inst (.i_pin_out(O_PIN_OUT),
		.i_pin_oe(O_PIN_OE), .o_pad(pad));
	initial begin
		forever #50 I_SYS_CLK = ~I_SYS_CLK;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task lim;
		if (n >= 20) begin
			miscompares++;
			stop_test;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge I_SYS_CLK);
		I_AXI_AWADDR <= a;
		I_AXI_WDATA <= d;
		I_AXI_AWVALID <= 1;
		I_AXI_WVALID <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge I_SYS_CLK);
			if (O_AXI_AWREADY) I_AXI_AWVALID <= 0;
			if (O_AXI_WREADY) I_AXI_WVALID <= 0;
			if (O_AXI_BVALID) break;
		end
		rsp = O_AXI_BRESP;
		lim;
	endtask
	task rd(input [7:0] a);
		@(posedge I_SYS_CLK);
		I_AXI_ARADDR <= a;
		I_AXI_ARVALID <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge I_SYS_CLK);
			if (O_AXI_ARREADY) I_AXI_ARVALID <= 0;
			if (O_AXI_RVALID) break;
		end
		rdat = O_AXI_RDATA;
		rsp = O_AXI_RRESP;
		lim;
	endtask
	initial begin
		repeat (12) @(posedge I_SYS_CLK);
		I_RESETN <= 1;
		rd(`MCOPC_OFF_LATCH);
		`CHK("latch reset", 32'h0000_0000, rdat)
		wr(`MCOPC_OFF_RUN, 1);
		wr(`MCOPC_OFF_DIR, 32'h0000_00FF);
		rd(`MCOPC_OFF_DIR);
		`CHK("dir", 32'h0000_00FF, rdat)
		wr(`MCOPC_OFF_LATCH, 32'h0000_0F0F);
		rd(`MCOPC_OFF_LATCH);
		`CHK("latch", 32'h0000_0F0F, rdat)
		rd(`MCOPC_OFF_PINS);
		`CHK("pins", 32'h0000_000F, rdat)
		`CHK("pad", 32'h0000_000F, pad)
		wr(`MCOPC_OFF_SEL, 1);
		wr(`MCOPC_OFF_RUN, 3);
		rd(`MCOPC_OFF_RUN);
		`CHK("run", 32'h0000_0003, rdat)
		rd(`MCOPC_OFF_SEL);
		`CHK("sel", 32'h0000_0001, rdat)
		wr(`MCOPC_OFF_DIR, 32'h0000_00F0);
		wr(`MCOPC_OFF_LATCH, 32'h0000_0030);
		I_CORE_AUX[38] <= 1;
		rd(`MCOPC_OFF_LATCH);
		`CHK("latch only", 32'h0000_0030, rdat)
		rd(`MCOPC_OFF_PINS);
		`CHK("wired or", 32'h0000_007F, rdat)
		wr(`MCOPC_OFF_RUN, 1);
		rd(`MCOPC_OFF_PINOE);
		`CHK("oe stopped", 32'h0000_00FF, rdat)
		`CHK("oe pin", 32'h0000_00FF, O_PIN_OE)
		rd(`MCOPC_OFF_PINS);
		`CHK("pins stopped", 32'h0000_000F, rdat)
		wr(`MCOPC_OFF_RUN, 3);
		rd(`MCOPC_OFF_LATCH);
		`CHK("restart", 32'h0000_0000, rdat)
		wr(`MCOPC_OFF_SEL, 0);
		wr(`MCOPC_OFF_BIT, 32'h0000_011F);
		rd(`MCOPC_OFF_BIT);
		`CHK("bit read", 32'h0000_011F, rdat)
		wr(`MCOPC_OFF_BIT, 32'h0000_0000);
		rd(`MCOPC_OFF_LATCH);
		`CHK("bit", 32'h8000_0F0E, rdat)
		wr(`MCOPC_OFF_RSEL, 32'h0000_0D0F);
		rd(`MCOPC_OFF_RSEL);
		`CHK("range sel", 32'h0000_0D0F, rdat)
		wr(`MCOPC_OFF_RDATA, 32'h0000_0005);
		rd(`MCOPC_OFF_LATCH);
		`CHK("range", 32'h8000_AF0E, rdat)
		rd(`MCOPC_OFF_RDATA);
		`CHK("range read", 32'h0000_0005, rdat)
		wr(`MCOPC_OFF_RSEL, 32'h0000_0F0D);
		wr(`MCOPC_OFF_RDATA, 32'h0000_0006);
		rd(`MCOPC_OFF_LATCH);
		`CHK("reversed", 32'h8000_6F0E, rdat)
		rd(`MCOPC_OFF_RDATA);
		`CHK("rev read", 32'h0000_0006, rdat)
		I_AXI_WSTRB <= 4'h2;
		wr(`MCOPC_OFF_LATCH, 32'hFFFF_FFFF);
		I_AXI_WSTRB <= 4'hF;
		rd(`MCOPC_OFF_LATCH);
		`CHK("strobe", 32'h8000_FF0E, rdat)
		rd(8'h40);
		`CHK("unmapped", 32'h0000_0000, rdat)
		`CHK("unmapped rsp", `MCOPC_RSP_SLVERR, rsp)
		wr(`MCOPC_OFF_PINS, 0);
		`CHK("ro rsp", `MCOPC_RSP_SLVERR, rsp)
		stop_test;
	end
endmodule
`default_nettype wire
